// file: core/bbcfg_pkg.sv
package bbcfg_pkg;

  // Register addresses on the control port
  localparam logic [6:0] ADDR_IO_POL  = 7'h02;
  localparam logic [6:0] ADDR_TX_CFG  = 7'h12;
  localparam logic [6:0] ADDR_RX_CFG  = 7'h14;
  localparam logic [6:0] ADDR_RXTX    = 7'h16;
  localparam logic [6:0] ADDR_CONV_CK = 7'h18;
  localparam logic [6:0] ADDR_PD_OVR  = 7'h1a;

  // Reset values
  localparam logic [7:0] RST_IO_POL  = 8'h00;
  localparam logic [7:0] RST_TX_CFG  = 8'h00;
  localparam logic [7:0] RST_RX_CFG  = 8'h00;
  localparam logic [7:0] RST_RXTX    = 8'h00;
  localparam logic [7:0] RST_CONV_CK = 8'h00;
  localparam logic [7:0] RST_PD_OVR  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field positions
  localparam int POL_CCA_HI   = 2;
  localparam int POL_MD_LO    = 1;
  localparam int TX_CCA_TIME  = 7;
  localparam int TX_CCA_MODE  = 5;
  localparam int TX_TST_PAT   = 4;
  localparam int TX_TST_EN    = 3;
  localparam int TX_ANT_FIX   = 2;
  localparam int TX_ANT_MODE  = 1;
  localparam int RX_CS2_SEL   = 7;
  localparam int RX_CIR_DET   = 6;
  localparam int RX_SFD_TO    = 4;
  localparam int RX_MD_SFD    = 3;
  localparam int RX_FOE_FORCE = 2;
  localparam int RX_ANT_FIX   = 1;
  localparam int RX_ANT_ONE   = 0;
  localparam int RT_CONT_CLK  = 7;
  localparam int RT_AC_COUPLE = 6;
  localparam int RT_JAPAN     = 5;
  localparam int RT_PINGPONG  = 4;
  localparam int RT_CCA_SAMP  = 3;
  localparam int RT_PRECURSOR = 0;
  localparam int CK_SRC_SDI   = 7;
  localparam int PD_MANUAL    = 0;

  // CCA modes
  localparam logic [1:0] CCA_ED      = 2'b00;
  localparam logic [1:0] CCA_CS      = 2'b01;
  localparam logic [1:0] CCA_ED_AND  = 2'b10;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_NS       = 20000;
  localparam int SAMP_LATE_NS  = 19900;
  localparam int SAMP_EARLY_NS = 15800;
  localparam logic [11:0] SLOT_CYC  = 12'(SLOT_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SAMP_LATE = 12'(SAMP_LATE_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SAMP_EARLY = 12'(SAMP_EARLY_NS / CLK_PERIOD_NS);
  localparam int SFD_TO0_US = 56;
  localparam int SFD_TO1_US = 64;
  localparam int SFD_TO2_US = 128;
  localparam int SFD_TO3_US = 144;

  typedef enum logic [1:0] {
    RX_IDLE    = 2'b00,
    RX_HUNT    = 2'b01,
    RX_HEADER  = 2'b11,
    RX_PAYLOAD = 2'b10
  } bbcfg_rx_e;

  typedef enum logic [1:0] {
    TST_OFF = 2'b00,
    TST_ALT = 2'b01,
    TST_CW  = 2'b11
  } bbcfg_tst_e;

  typedef struct packed {
    logic energy_detect;
    logic carrier_sense_one;
    logic signal_quality_one;
  } bbcfg_det_s;

  typedef struct packed {
    logic standby;
    logic transmit_sleep;
    logic rx_sleep;
    logic iq_sleep;
    logic an_tx_shdn;
    logic an_rx_shdn;
    logic an_standby;
  } bbcfg_pd_s;

  localparam bbcfg_pd_s PD_ALL_ON = 7'h7f;

endpackage

// file: core/bbcfg_sync2.sv
module bbcfg_sync2
  import bbcfg_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic [W-1:0] async_in,  // Pin levels
  output logic      [W-1:0] sync_out   // Synchronised levels
);

  logic [W-1:0] meta;

  // Two flops per bit; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        meta[i]     <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule

// file: core/bbcfg_top.sv
// Operation
// - Sample bit picks 19.9 or 15.8 us
// - CCA source field combines energy, carrier terms
// - Test pattern: alternating bits or all ones
// - Test enable runs chosen pattern, else normal
// - TX antenna: fixed bit or last header
// - CS2 estimate from dot product or quality
// - CHANNEL_RESPONSE_ESTIMATE clock in acquisition or after detect
// - SFD hunt time-out 56/64/128/144 us
// - Modem ready after CRC16 or after SFD
// - Force frequency offset estimation per bit
// - RX dual diversity or single fixed antenna
// - Continuous RX clocks override detect gating
// - Filter weights US or Japan set
// - Ping-pong differential encode enable bit
// - CCA immediate or sampled once per slot
// - Three-bit precursor for CHANNEL_RESPONSE_ESTIMATE estimator
// - Converter clocks internal or from serial pin
// - Seven converter clock gates, one stops
// - Power-down automatic or manual override
// - Manual power-down bits assert when one
// - CCA pin polarity bit: one active high
// - Modem ready polarity bit: one active low
module bbcfg_top
  import bbcfg_pkg::*;
#(
  parameter logic [15:0] SFD_CYC0 = 16'(SFD_TO0_US * 1000 / CLK_PERIOD_NS),
  parameter logic [15:0] SFD_CYC1 = 16'(SFD_TO1_US * 1000 / CLK_PERIOD_NS),
  parameter logic [15:0] SFD_CYC2 = 16'(SFD_TO2_US * 1000 / CLK_PERIOD_NS),
  parameter logic [15:0] SFD_CYC3 = 16'(SFD_TO3_US * 1000 / CLK_PERIOD_NS)
) (
  input  wire logic       clk_sys,            // 100 MHz clock
  input  wire logic       rstn,               // Async reset, active low
  input  wire logic       reg_wr,             // Register write strobe
  input  wire logic       reg_rd,             // Register read strobe
  input  wire logic [6:0] reg_addr,           // Register address
  input  wire logic [7:0] reg_wdata,          // Write data
  output logic      [7:0] reg_rdata,          // Read data
  output logic            reg_rvalid,         // Read data valid
  input  wire logic       transmit_enable_in, // TX enable pin
  input  wire logic       receive_enable_in,  // RX enable pin
  input  wire bbcfg_det_s det,                // Detector levels
  input  wire logic       signal_detect,      // Signal detected pulse
  input  wire logic       sfd_found,          // SFD found pulse
  input  wire logic       hdr_crc_ok,         // Header CRC good pulse
  input  wire logic       rx_end,             // Frame end pulse
  input  wire logic       div_antenna,        // Diversity antenna choice
  input  wire logic       chip_tick,          // Chip rate enable
  input  wire logic       dot_cs2,            // Dot product CS2 result
  input  wire logic       sq_cs2,             // Correlator SQ CS2 result
  output logic            channel_busy_flag,  // CCA pin level
  output logic            modem_ready_out,    // Modem ready pin level
  output logic            antenna_select_out, // Antenna select pin
  output logic            sfd_timeout,        // SFD hunt abandoned pulse
  output logic            carrier_sense_two,  // Initial CS2 estimate
  output logic            rx_clk_run,         // RX 22/44 MHz clock enable
  output logic            cir_clk_run,        // CHANNEL_RESPONSE_ESTIMATE and dot clock enable
  output logic            foe_force,          // Force offset estimation
  output logic            region_japan,       // Filter weight set
  output logic            pingpong_en,        // Ping-pong encode enable
  output logic            adc_ac_couple,      // A/D input coupling
  output logic      [2:0] precursor,          // CHANNEL_RESPONSE_ESTIMATE precursor value
  output bbcfg_tst_e      tx_test_mode,       // Active test pattern
  output logic            tx_test_chip,       // Test chip value
  output logic      [6:0] conv_clk_en,        // Converter clock enables
  output logic            conv_clk_from_sdi,  // Converter clock source
  output bbcfg_pd_s       pd                  // Power-down controls
);

  logic [7:0] io_polarity;
  logic [7:0] tx_configure;
  logic [7:0] rx_configure;
  logic [7:0] rx_tx_configure;
  logic [7:0] converter_clock_gating;
  logic [7:0] power_down_override;
  logic [1:0] pin_sync;
  logic       tx_en_s;
  logic       rx_en_s;
  logic       carrier_term;
  logic       busy_raw;
  logic       busy_hold;
  logic       cca_sampled;
  logic [11:0] slot_cnt;
  logic [11:0] samp_pt;
  logic [15:0] hunt_cnt;
  logic [15:0] hunt_lim;
  bbcfg_rx_e  rx_state;
  bbcfg_rx_e  next_rx_state;
  logic       hunt_expire;
  logic       last_hdr_ant;
  logic       next_ant;
  bbcfg_pd_s  pd_auto;

  bbcfg_sync2 #(.W(2)) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({transmit_enable_in, receive_enable_in}),
    .sync_out (pin_sync)
  );
  assign tx_en_s = pin_sync[1];
  assign rx_en_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      io_polarity            <= RST_IO_POL;
      tx_configure           <= RST_TX_CFG;
      rx_configure           <= RST_RX_CFG;
      rx_tx_configure        <= RST_RXTX;
      converter_clock_gating <= RST_CONV_CK;
      power_down_override    <= RST_PD_OVR;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_IO_POL:  io_polarity            <= reg_wdata;
        ADDR_TX_CFG:  tx_configure           <= reg_wdata;
        ADDR_RX_CFG:  rx_configure           <= reg_wdata;
        ADDR_RXTX:    rx_tx_configure        <= reg_wdata;
        ADDR_CONV_CK: converter_clock_gating <= reg_wdata;
        ADDR_PD_OVR:  power_down_override    <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= RD_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_IO_POL:  reg_rdata <= io_polarity;
          ADDR_TX_CFG:  reg_rdata <= tx_configure;
          ADDR_RX_CFG:  reg_rdata <= rx_configure;
          ADDR_RXTX:    reg_rdata <= rx_tx_configure;
          ADDR_CONV_CK: reg_rdata <= converter_clock_gating;
          ADDR_PD_OVR:  reg_rdata <= power_down_override;
          default:      reg_rdata <= RD_UNMAPPED;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear channel assessment

  assign carrier_term = det.carrier_sense_one | det.signal_quality_one;
  assign cca_sampled  = rx_tx_configure[RT_CCA_SAMP];
  assign samp_pt      = tx_configure[TX_CCA_TIME] ? SAMP_EARLY : SAMP_LATE;

  always_comb begin
    case (tx_configure[TX_CCA_MODE +: 2])
      CCA_ED:     busy_raw = det.energy_detect;
      CCA_CS:     busy_raw = carrier_term;
      CCA_ED_AND: busy_raw = det.energy_detect & carrier_term;
      default:    busy_raw = det.energy_detect | carrier_term;
    endcase
  end

  // Free-running slot timer; sample taken at chosen point
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot_cnt  <= 12'h000;
      busy_hold <= 1'b0;
    end else begin
      slot_cnt <= (slot_cnt == SLOT_CYC - 12'h001) ? 12'h000 : slot_cnt + 12'h001;
      if (slot_cnt == samp_pt - 12'h001) begin
        busy_hold <= busy_raw;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channel_busy_flag <= 1'b1;
    end else begin
      channel_busy_flag <= (cca_sampled ? busy_hold : busy_raw)
                           ~^ io_polarity[POL_CCA_HI];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive sequence and SFD time-out

  always_comb begin
    case (rx_configure[RX_SFD_TO +: 2])
      2'b00:   hunt_lim = SFD_CYC0;
      2'b01:   hunt_lim = SFD_CYC1;
      2'b10:   hunt_lim = SFD_CYC2;
      default: hunt_lim = SFD_CYC3;
    endcase
  end
  assign hunt_expire = (rx_state == RX_HUNT) && (hunt_cnt >= hunt_lim - 16'h0001);

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE:    if (signal_detect) next_rx_state = RX_HUNT;
      RX_HUNT:    if (sfd_found) next_rx_state = RX_HEADER;
                  else if (hunt_expire) next_rx_state = RX_IDLE;
      RX_HEADER:  if (rx_end) next_rx_state = RX_IDLE;
                  else if (hdr_crc_ok) next_rx_state = RX_PAYLOAD;
      RX_PAYLOAD: if (rx_end) next_rx_state = RX_IDLE;
      default:    next_rx_state = RX_IDLE;
    endcase
    if (!rx_en_s) next_rx_state = RX_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_state    <= RX_IDLE;
      hunt_cnt    <= 16'h0000;
      sfd_timeout <= 1'b0;
    end else begin
      rx_state    <= next_rx_state;
      hunt_cnt    <= (rx_state == RX_HUNT) ? hunt_cnt + 16'h0001 : 16'h0000;
      sfd_timeout <= hunt_expire && !sfd_found && rx_en_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modem_ready_out <= 1'b0;
    end else begin
      modem_ready_out <= ((rx_state == RX_PAYLOAD) ||
                          (rx_state == RX_HEADER && rx_configure[RX_MD_SFD]))
                         ^ io_polarity[POL_MD_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Antenna selection

  always_comb begin
    if (tx_en_s) begin
      next_ant = tx_configure[TX_ANT_MODE] ? last_hdr_ant : tx_configure[TX_ANT_FIX];
    end else begin
      next_ant = rx_configure[RX_ANT_ONE] ? rx_configure[RX_ANT_FIX] : div_antenna;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      antenna_select_out <= 1'b0;
      last_hdr_ant       <= 1'b0;
    end else begin
      antenna_select_out <= next_ant;
      if (rx_state == RX_HEADER && hdr_crc_ok) begin
        last_hdr_ant <= antenna_select_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver controls and clock gating

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      carrier_sense_two <= 1'b0;
      rx_clk_run        <= 1'b0;
      cir_clk_run       <= 1'b0;
      foe_force         <= 1'b0;
      region_japan      <= 1'b0;
      pingpong_en       <= 1'b0;
      adc_ac_couple     <= 1'b0;
      precursor         <= 3'h0;
    end else begin
      carrier_sense_two <= rx_configure[RX_CS2_SEL] ? sq_cs2 : dot_cs2;
      rx_clk_run  <= rx_tx_configure[RT_CONT_CLK] | rx_en_s;
      cir_clk_run <= rx_tx_configure[RT_CONT_CLK] |
                     (rx_configure[RX_CIR_DET] ? (rx_state != RX_IDLE) : rx_en_s);
      foe_force     <= rx_configure[RX_FOE_FORCE];
      region_japan  <= rx_tx_configure[RT_JAPAN];
      pingpong_en   <= rx_tx_configure[RT_PINGPONG];
      adc_ac_couple <= rx_tx_configure[RT_AC_COUPLE];
      precursor     <= rx_tx_configure[RT_PRECURSOR +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit test patterns

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_test_mode <= TST_OFF;
      tx_test_chip <= 1'b0;
    end else begin
      if (!tx_configure[TX_TST_EN]) begin
        tx_test_mode <= TST_OFF;
        tx_test_chip <= 1'b0;
      end else if (tx_configure[TX_TST_PAT]) begin
        tx_test_mode <= TST_CW;
        tx_test_chip <= 1'b1;
      end else begin
        tx_test_mode <= TST_ALT;
        if (chip_tick) tx_test_chip <= ~tx_test_chip;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clocks and power-down

  assign pd_auto = '{
    standby:        !(tx_en_s | rx_en_s),
    transmit_sleep: !tx_en_s,
    rx_sleep:       !rx_en_s,
    iq_sleep:       !(tx_en_s | rx_en_s),
    an_tx_shdn:     !tx_en_s,
    an_rx_shdn:     !rx_en_s,
    an_standby:     !(tx_en_s | rx_en_s)
  };

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_clk_en       <= 7'h7f;
      conv_clk_from_sdi <= 1'b0;
      pd                <= PD_ALL_ON;
    end else begin
      conv_clk_en       <= ~converter_clock_gating[6:0];
      conv_clk_from_sdi <= converter_clock_gating[CK_SRC_SDI];
      pd <= power_down_override[PD_MANUAL] ? bbcfg_pd_s'(power_down_override[7:1])
                                           : pd_auto;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_cca_immediate: assert property (!$past(cca_sampled) |->
    channel_busy_flag == ($past(busy_raw) ~^ $past(io_polarity[POL_CCA_HI])))
    else $error("CCA pin does not follow live busy term");
  a_cca_slot_hold: assert property ((slot_cnt != samp_pt - 12'h001) |=> $stable(busy_hold))
    else $error("Sampled CCA changed outside sample point");
  a_sfd_hunt_end: assert property ((hunt_expire && !sfd_found && rx_en_s) |=>
    (rx_state == RX_IDLE) && sfd_timeout)
    else $error("SFD hunt not abandoned at time-out");
  a_hunt_bound: assert property ((rx_state == RX_HUNT) |-> (hunt_cnt < hunt_lim))
    else $error("SFD hunt ran past time-out");
  a_md_ready_sfd: assert property (($past(rx_state) == RX_HEADER &&
    $past(rx_configure[RX_MD_SFD])) |-> modem_ready_out != $past(io_polarity[POL_MD_LO]))
    else $error("Modem ready not asserted after SFD");
  a_md_ready_idle: assert property (($past(rx_state) == RX_IDLE) |->
    modem_ready_out == $past(io_polarity[POL_MD_LO]))
    else $error("Modem ready asserted while idle");
  a_ant_tx_fixed: assert property (($past(tx_en_s) && !$past(tx_configure[TX_ANT_MODE])) |->
    antenna_select_out == $past(tx_configure[TX_ANT_FIX]))
    else $error("TX antenna not the fixed choice");
  a_ant_rx_single: assert property ((!$past(tx_en_s) && $past(rx_configure[RX_ANT_ONE])) |->
    antenna_select_out == $past(rx_configure[RX_ANT_FIX]))
    else $error("RX single antenna choice ignored");
  a_cont_clock: assert property ($past(rx_tx_configure[RT_CONT_CLK]) |->
    rx_clk_run && cir_clk_run)
    else $error("Continuous RX clocks stopped");
  a_test_cw: assert property (($past(tx_configure[TX_TST_EN]) && $past(tx_configure[TX_TST_PAT]))
    |-> tx_test_chip && tx_test_mode == TST_CW)
    else $error("CW test chips not all ones");
  a_conv_gate: assert property (conv_clk_en == ~$past(converter_clock_gating[6:0]))
    else $error("Converter clock gate mismatch");
  a_pd_manual: assert property ($past(power_down_override[PD_MANUAL]) |->
    pd == $past(power_down_override[7:1]))
    else $error("Manual power-down not applied");
  a_readback: assert property ((reg_wr && reg_addr == ADDR_RX_CFG) ##1
    (reg_rd && reg_addr == ADDR_RX_CFG && !reg_wr) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("Register read back wrong value");

  c_sfd_timeout:  cover property (sfd_timeout);
  c_payload:      cover property (rx_state == RX_HEADER ##1 rx_state == RX_PAYLOAD);
  c_sampled_busy: cover property (cca_sampled && $rose(busy_hold));
  c_manual_pd:    cover property (power_down_override[PD_MANUAL] && tx_en_s);

endmodule

// file: sim/bbcfg_host.sv
module bbcfg_host
  import bbcfg_pkg::*;
(
  input  wire logic       clk_sys,   // Clock
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic      [6:0] reg_addr,  // Address
  output logic      [7:0] reg_wdata  // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] dv);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == ADDR_TX_CFG) ? {dv[7:1], 1'b0} : dv;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Write, then read the same register on the very next cycle
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] dv);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == ADDR_TX_CFG) ? {dv[7:1], 1'b0} : dv;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Receiver start-up sequence
  task automatic init;
    wr(ADDR_RXTX, 8'h80);
    wr(ADDR_RXTX, 8'h00);
  endtask
endmodule

// file: sim/baseband_txrx_config_regs_test.sv
module baseband_txrx_config_regs_test
  import bbcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       reg_wr, reg_rd, reg_rvalid, transmit_enable_in = 1'b0, receive_enable_in = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  bbcfg_det_s det = '0;
  logic [3:0] ev = 4'h0;
  logic       div_antenna = 1'b0, chip_tick = 1'b0, dot_cs2 = 1'b0, sq_cs2 = 1'b0;
  logic       channel_busy_flag, modem_ready_out, antenna_select_out, sfd_timeout;
  logic       carrier_sense_two, rx_clk_run, cir_clk_run, foe_force, region_japan;
  logic       pingpong_en, adc_ac_couple, conv_clk_from_sdi, tx_test_chip;
  logic [2:0] precursor;
  logic [6:0] conv_clk_en;
  bbcfg_tst_e tx_test_mode;
  bbcfg_pd_s  pd;
  logic [7:0] exp_q[$];
  int         errors = 0, samples_checked = 0, n;
  logic [6:0] addrs[5] = '{ADDR_TX_CFG, ADDR_RX_CFG, ADDR_RXTX, ADDR_CONV_CK, ADDR_PD_OVR};
  int         lim[4] = '{20, 24, 40, 48};

  always #5 clk_sys = ~clk_sys;

  bbcfg_host host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  bbcfg_top #(.SFD_CYC0(16'd20), .SFD_CYC1(16'd24), .SFD_CYC2(16'd40), .SFD_CYC3(16'd48))
  dut (
    .clk_sys, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .transmit_enable_in, .receive_enable_in, .det, .signal_detect(ev[0]), .sfd_found(ev[1]),
    .hdr_crc_ok(ev[2]), .rx_end(ev[3]), .div_antenna, .chip_tick, .dot_cs2, .sq_cs2,
    .channel_busy_flag, .modem_ready_out, .antenna_select_out, .sfd_timeout,
    .carrier_sense_two, .rx_clk_run, .cir_clk_run, .foe_force, .region_japan, .pingpong_en,
    .adc_ac_couple, .precursor, .tx_test_mode, .tx_test_chip, .conv_clk_en,
    .conv_clk_from_sdi, .pd
  );

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic st(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait for the busy pin to reach a level
  task automatic wait_cca(input logic lvl);
    n = 0;
    while (channel_busy_flag !== lvl && n < 2100) begin
      st(1);
      n++;
    end
    if (n == 2100) begin
      chk("cca_wait", 8'h01, 8'h00);
      close_out();
    end
  endtask

  task automatic rdx(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'b1;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask

  function automatic logic busy(input int m, input logic [2:0] v);
    logic c;
    c = v[1] | v[0];
    case (m)
      0: return v[2];
      1: return c;
      2: return v[2] & c;
      default: return v[2] | c;
    endcase
  endfunction

  // Read data checker
  always @(posedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rd_extra", 8'h01, 8'h00);
      else chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(56));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    st(1);
    foreach (addrs[i]) rdx(addrs[i], 8'h00);
    rdx(7'h30, RD_UNMAPPED);
    chk("pd_auto", {1'b0, pd}, 8'h7f);
    chk("conv_rst", {1'b0, conv_clk_en}, 8'h7f);
    host.init();
    foreach (addrs[i]) begin
      d = 8'($urandom);
      if (i == 0) d[0] = 1'b0;
      host.wr(addrs[i], d);
      rdx(addrs[i], d);
    end
    d = 8'($urandom);
    exp_q.push_back(d);
    host.wr_rd(ADDR_RX_CFG, d);
    d = 8'($urandom) & 8'h77;
    host.wr(ADDR_RXTX, d);
    st(2);
    chk("precursor", {5'h0, precursor}, {5'h0, d[2:0]});
    chk("japan", region_japan, d[5]);
    chk("pingpong", pingpong_en, d[4]);
    host.wr(ADDR_CONV_CK, d ^ 8'hc3);
    st(2);
    chk("conv_en", {1'b0, conv_clk_en}, {1'b0, ~(d[6:0] ^ 7'h43)});
    chk("conv_src", conv_clk_from_sdi, !d[7]);
    host.wr(ADDR_PD_OVR, d | 8'h01);
    st(2);
    chk("pd_man", {1'b0, pd}, {1'b0, d[7:1]});
    @(posedge clk_sys);
    dot_cs2 <= 1'($urandom);
    sq_cs2 <= 1'($urandom);
    host.wr(ADDR_RX_CFG, d);
    st(2);
    chk("cs2", carrier_sense_two, d[7] ? sq_cs2 : dot_cs2);
    chk("foe", foe_force, d[2]);
    host.wr(ADDR_RXTX, 8'h80);
    st(2);
    chk("rx_clk", rx_clk_run, 1'b1);
    host.wr(ADDR_IO_POL, 8'h04);
    for (int m = 0; m < 4; m++) begin
      host.wr(ADDR_TX_CFG, 8'(m << 5));
      for (int v = 0; v < 8; v++) begin
        @(posedge clk_sys);
        det <= bbcfg_det_s'(3'(v));
        st(2);
        chk("cca", channel_busy_flag, busy(m, 3'(v)));
      end
    end
    host.wr(ADDR_IO_POL, 8'h00);
    st(2);
    chk("cca_lo", channel_busy_flag, 1'b0);
    // Sampled mode: late sample, then early point in the next slot
    host.wr(ADDR_TX_CFG, 8'h00);
    det <= '0;
    host.wr(ADDR_RXTX, 8'h08);
    host.wr(ADDR_IO_POL, 8'h04);
    st(2);
    wait_cca(1'b0);
    @(posedge clk_sys);
    det <= bbcfg_det_s'(3'h4);
    wait_cca(1'b1);
    host.wr(ADDR_TX_CFG, 8'h80);
    det <= '0;
    wait_cca(1'b0);
    chk("cca_slot", n == SLOT_CYC - SAMP_LATE + SAMP_EARLY - 2, 1'b1);
    host.wr(ADDR_TX_CFG, 8'h18);
    st(2);
    chk("tst_cw", tx_test_mode, TST_CW);
    chk("cw_chip", tx_test_chip, 1'b1);
    host.wr(ADDR_TX_CFG, 8'h08);
    st(2);
    chk("tst_alt", tx_test_mode, TST_ALT);
    d[0] = tx_test_chip;
    @(posedge clk_sys);
    chip_tick <= 1'b1;
    @(posedge clk_sys);
    chip_tick <= 1'b0;
    st(2);
    chk("alt_chip", tx_test_chip, !d[0]);
    host.wr(ADDR_TX_CFG, 8'h04);
    @(posedge clk_sys);
    transmit_enable_in <= 1'b1;
    st(5);
    chk("tst_off", tx_test_mode, TST_OFF);
    chk("tx_ant", antenna_select_out, 1'b1);
    @(posedge clk_sys);
    transmit_enable_in <= 1'b0;
    receive_enable_in <= 1'b1;
    host.wr(ADDR_RX_CFG, 8'h03);
    st(5);
    chk("rx_ant", antenna_select_out, 1'b1);
    host.wr(ADDR_RX_CFG, 8'h49);
    st(2);
    chk("rx_ant", antenna_select_out, 1'b0);
    chk("cir_clk", cir_clk_run, 1'b0);
    host.wr(ADDR_IO_POL, 8'h06);
    pulse(0);
    pulse(1);
    st(2);
    chk("md_sfd", modem_ready_out, 1'b0);
    chk("cir_det", cir_clk_run, 1'b1);
    pulse(3);
    host.wr(ADDR_RX_CFG, 8'h00);
    pulse(0);
    pulse(1);
    st(2);
    chk("md_wait", modem_ready_out, 1'b1);
    @(posedge clk_sys);
    div_antenna <= 1'b1;
    pulse(2);
    st(2);
    chk("md_crc", modem_ready_out, 1'b0);
    pulse(3);
    for (int c = 0; c < 4; c++) begin
      host.wr(ADDR_RX_CFG, 8'(c << 4));
      pulse(0);
      n = 0;
      while (sfd_timeout !== 1'b1 && n < 100) begin
        st(1);
        n++;
      end
      chk("sfd_to", n >= lim[c] - 2 && n <= lim[c] + 2, 1'b1);
      if (n == 100) close_out();
    end
    host.wr(ADDR_TX_CFG, 8'h02);
    @(posedge clk_sys);
    transmit_enable_in <= 1'b1;
    div_antenna <= 1'b0;
    st(5);
    chk("tx_hdr_ant", antenna_select_out, 1'b1);
    st(3);
    chk("q_left", 8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule
